// *** hdl/odir_consts.svh ***
// Offsets, field positions, reset values and timing figures of the divider register bank
`ifndef ODIR_CONSTS_SVH
`define ODIR_CONSTS_SVH

// Register offsets
`define ODIR_ADDR_VCO_LOW   8'h0A
`define ODIR_ADDR_DIV_CTRL  8'h0B
`define ODIR_ADDR_DIS_CFG   8'h0E
`define ODIR_ADDR_SOFT_RST  8'h80
`define ODIR_ADDR_OUT_CAL   8'h84

// Field positions
`define ODIR_VCO_HI_RANGE   1:0
`define ODIR_FINAL_RANGE    6:4
`define ODIR_DIS_RANGE      5:4
`define ODIR_RST_BIT        7
`define ODIR_OE_BIT         2
`define ODIR_CAL_BIT        0

// Reset values
`define ODIR_VCO_DIV_RST    10'h00A
`define ODIR_FINAL_DIV_RST  3'h0
`define ODIR_DIS_CFG_RST    2'h0
`define ODIR_OE_RST         1'b1
`define ODIR_CAL_RST        1'b0

// Encodings
`define ODIR_FINAL_MAX_CODE 3'h5
`define ODIR_DIS_LOW        2'h2
`define ODIR_DIS_HIGH       2'h1

// Timing figures
`define ODIR_SYS_CLK_KHZ        125000
`define ODIR_CAL_MAX_MS         10
`define ODIR_LINK_CLK_PERIOD_NS 30
`define ODIR_SDA_TIMEOUT_US     30000

// Bus address, arbitrary value
`define ODIR_SLAVE_ADDR_DEF 7'h2A

`endif

// *** hdl/odir_pkg.sv ***
// Types and shared decode functions of the divider register bank
`include "odir_consts.svh"

package odir_pkg;

  typedef logic [9:0] odir_vco_div_t;
  typedef logic [5:0] odir_ratio_t;
  typedef logic [7:0] odir_byte_t;

  typedef enum logic [3:0] {
    ODIR_IDLE      = 4'h0,
    ODIR_ADDR      = 4'h1,
    ODIR_ADDR_ACK  = 4'h2,
    ODIR_REG       = 4'h3,
    ODIR_REG_ACK   = 4'h4,
    ODIR_WDATA     = 4'h5,
    ODIR_WDATA_ACK = 4'h6,
    ODIR_RDATA     = 4'h7,
    ODIR_RDATA_ACK = 4'h8
  } odir_link_state_t;

  // Final divider code to ratio, zero for reserved codes
  function automatic odir_ratio_t odir_ratio(input logic [2:0] code);
    return (code <= `ODIR_FINAL_MAX_CODE) ? odir_ratio_t'(6'h01 << code) : 6'h00;
  endfunction

  // Overall divide of the two stages in series
  function automatic logic [15:0] odir_total(input odir_vco_div_t vco, input odir_ratio_t ratio);
    return {6'h00, vco} * {10'h000, ratio};
  endfunction

endpackage

// *** hdl/odir_sync2.sv ***
// Two flip-flop level synchroniser with asynchronous clear
`timescale 1ns/1ps

module odir_sync2 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level in and out
  input  wire logic d,
  output logic      q
);

  logic meta;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // odir_sync2

// *** hdl/odir_xfer.sv ***
// Toggle pulse crossing from one clock domain to another
`timescale 1ns/1ps

module odir_xfer (
  // Source side
  input  wire logic src_clk,
  input  wire logic src_rst_n,
  input  wire logic src_pulse,
  // Destination side
  input  wire logic dst_clk,
  input  wire logic dst_rst_n,
  output logic      dst_pulse
);

  logic src_tog;
  logic dst_tog;
  logic dst_tog_d;

  // Event becomes a level change
  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      src_tog <= 1'b0;
    end else if (src_pulse) begin
      src_tog <= ~src_tog;
    end
  end

  odir_sync2 u_sync (
    .clk   (dst_clk),
    .rst_n (dst_rst_n),
    .d     (src_tog),
    .q     (dst_tog)
  );

  // Level change back to a one-cycle pulse
  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      dst_tog_d <= 1'b0;
      dst_pulse <= 1'b0;
    end else begin
      dst_tog_d <= dst_tog;
      dst_pulse <= dst_tog ^ dst_tog_d;
    end
  end

endmodule // odir_xfer

// *** hdl/odir_regs.sv ***
// Serial-bus register bank for oscillator dividers, output state and calibration
`timescale 1ns/1ps
`include "odir_consts.svh"

module odir_regs #(
  parameter logic [6:0] SLAVE_ADDR         = `ODIR_SLAVE_ADDR_DEF,
  parameter int         CAL_CYCLES         = `ODIR_CAL_MAX_MS * `ODIR_SYS_CLK_KHZ,
  parameter int         SDA_TIMEOUT_CYCLES = `ODIR_SDA_TIMEOUT_US * 1000 / `ODIR_LINK_CLK_PERIOD_NS
) (
  // System clock and reset
  input  wire logic                  SYS_CLK,
  input  wire logic                  RESETN,
  // Serial bus
  input  wire logic                  LINK_CLK,
  input  wire logic                  SCL_I,
  input  wire logic                  SDA_I,
  output logic                       SDA_O,
  output logic                       SDA_OE_N,
  // Divider settings
  output odir_pkg::odir_vco_div_t    VCO_OUTPUT_DIVIDER,
  output odir_pkg::odir_ratio_t      FINAL_DIVIDE_RATIO,
  output logic [15:0]                TOTAL_DIVIDE,
  // Output driver and calibration
  output logic                       DRIVER_EN,
  output logic                       CLK_OE_N,
  output logic                       CLK_LEVEL,
  output logic                       CAL_BUSY
);
  import odir_pkg::*;

  logic             link_rst_n;
  logic             scl_n_s;
  logic             sda_n_s;
  logic             scl_s;
  logic             sda_s;
  logic             scl_d;
  logic             sda_d;
  logic             start_cond;
  logic             stop_cond;
  logic             scl_rise;
  logic             scl_fall;
  logic [23:0]      to_cnt;
  logic             timeout_hit;
  odir_link_state_t state;
  odir_byte_t       shreg;
  logic [2:0]       bit_cnt;
  logic             byte_full;
  logic             rw;
  odir_byte_t       ptr;
  logic             sda_oe_n;
  logic             req_pulse;
  logic             req_we;
  odir_byte_t       req_addr;
  odir_byte_t       req_wdata;
  logic             done_pulse;
  odir_byte_t       rd_buf;
  logic             sys_req;
  logic             sys_done;
  odir_byte_t       sys_rd_data;
  logic             wr_en;
  logic             rd_en;
  logic             soft_rst;
  logic [7:0]       vco_low;
  logic [1:0]       vco_hi;
  logic [2:0]       final_code;
  odir_ratio_t      final_ratio;
  logic [1:0]       dis_cfg;
  logic             oe;
  logic             cal_busy;
  logic [23:0]      cal_cnt;
  odir_vco_div_t    vco_div;

  // Link reset release and pin synchronisers
  odir_sync2 u_rst_sync (.clk(LINK_CLK), .rst_n(RESETN), .d(1'b1), .q(link_rst_n));
  // Pins pass inverted so the cleared stages match the idle-high bus
  odir_sync2 u_scl_sync (.clk(LINK_CLK), .rst_n(link_rst_n), .d(~SCL_I), .q(scl_n_s));
  odir_sync2 u_sda_sync (.clk(LINK_CLK), .rst_n(link_rst_n), .d(~SDA_I), .q(sda_n_s));
  assign scl_s = ~scl_n_s;
  assign sda_s = ~sda_n_s;

  // Pin history for edge and condition detection
  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Bus conditions, oversampled at both bus rates
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;

  // Stuck data line counter, saturates at the limit
  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      to_cnt <= 24'h000000;
    end else if (sda_s) begin
      to_cnt <= 24'h000000;
    end else if (!timeout_hit) begin
      to_cnt <= to_cnt + 24'h000001;
    end
  end
  assign timeout_hit = (to_cnt == 24'(SDA_TIMEOUT_CYCLES));

  // Serial slave engine
  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state     <= ODIR_IDLE;
      shreg     <= 8'h00;
      bit_cnt   <= 3'h0;
      byte_full <= 1'b0;
      rw        <= 1'b0;
      ptr       <= 8'h00;
      sda_oe_n  <= 1'b1;
      req_pulse <= 1'b0;
      req_we    <= 1'b0;
      req_addr  <= 8'h00;
      req_wdata <= 8'h00;
    end else begin
      req_pulse <= 1'b0;
      if (timeout_hit || stop_cond) begin
        state    <= ODIR_IDLE;
        sda_oe_n <= 1'b1;
      end else if (start_cond) begin
        state     <= ODIR_ADDR;
        bit_cnt   <= 3'h0;
        byte_full <= 1'b0;
        sda_oe_n  <= 1'b1;
      end else if (scl_rise) begin
        unique case (state)
          ODIR_ADDR, ODIR_REG, ODIR_WDATA: begin
            shreg     <= {shreg[6:0], sda_s};
            bit_cnt   <= bit_cnt + 3'h1;
            byte_full <= (bit_cnt == 3'h7);
          end
          ODIR_RDATA_ACK: begin
            if (sda_s) begin
              state <= ODIR_IDLE;
            end else begin
              req_we    <= 1'b0;
              req_addr  <= ptr;
              req_pulse <= 1'b1;
            end
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        unique case (state)
          ODIR_ADDR: begin
            if (byte_full) begin
              byte_full <= 1'b0;
              if (shreg[7:1] == SLAVE_ADDR) begin
                rw       <= shreg[0];
                sda_oe_n <= 1'b0;
                state    <= ODIR_ADDR_ACK;
                if (shreg[0]) begin
                  req_we    <= 1'b0;
                  req_addr  <= ptr;
                  req_pulse <= 1'b1;
                end
              end else begin
                state <= ODIR_IDLE;
              end
            end
          end
          ODIR_REG: begin
            if (byte_full) begin
              byte_full <= 1'b0;
              ptr       <= shreg;
              sda_oe_n  <= 1'b0;
              state     <= ODIR_REG_ACK;
            end
          end
          ODIR_WDATA: begin
            if (byte_full) begin
              byte_full <= 1'b0;
              req_we    <= 1'b1;
              req_addr  <= ptr;
              req_wdata <= shreg;
              req_pulse <= 1'b1;
              ptr       <= ptr + 8'h01;
              sda_oe_n  <= 1'b0;
              state     <= ODIR_WDATA_ACK;
            end
          end
          ODIR_ADDR_ACK, ODIR_RDATA_ACK: begin
            if (rw) begin
              shreg    <= rd_buf;
              sda_oe_n <= rd_buf[7];
              bit_cnt  <= 3'h0;
              ptr      <= ptr + 8'h01;
              state    <= ODIR_RDATA;
            end else begin
              sda_oe_n <= 1'b1;
              bit_cnt  <= 3'h0;
              state    <= ODIR_REG;
            end
          end
          ODIR_REG_ACK, ODIR_WDATA_ACK: begin
            sda_oe_n <= 1'b1;
            bit_cnt  <= 3'h0;
            state    <= ODIR_WDATA;
          end
          ODIR_RDATA: begin
            if (bit_cnt == 3'h7) begin
              sda_oe_n <= 1'b1;
              state    <= ODIR_RDATA_ACK;
            end else begin
              shreg    <= {shreg[6:0], 1'b0};
              sda_oe_n <= shreg[6];
              bit_cnt  <= bit_cnt + 3'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Open-drain data pin only ever pulls low
  assign SDA_O    = 1'b0;
  assign SDA_OE_N = sda_oe_n;

  // Requests to the register side and answers back
  odir_xfer u_req (.src_clk(LINK_CLK), .src_rst_n(link_rst_n), .src_pulse(req_pulse),
                   .dst_clk(SYS_CLK), .dst_rst_n(RESETN), .dst_pulse(sys_req));
  odir_xfer u_done (.src_clk(SYS_CLK), .src_rst_n(RESETN), .src_pulse(sys_done),
                    .dst_clk(LINK_CLK), .dst_rst_n(link_rst_n), .dst_pulse(done_pulse));

  // Read answer, stable in the register domain when captured
  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_buf <= 8'h00;
    end else if (done_pulse) begin
      rd_buf <= sys_rd_data;
    end
  end

  // Request decode, payload held still by the link side
  assign wr_en    = sys_req & req_we;
  assign rd_en    = sys_req & ~req_we;
  assign soft_rst = wr_en && (req_addr == `ODIR_ADDR_SOFT_RST) && req_wdata[`ODIR_RST_BIT];
  assign vco_div  = {vco_hi, vco_low};

  // Register file writes
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      vco_low     <= 8'(`ODIR_VCO_DIV_RST & 10'h0FF);
      vco_hi      <= 2'h0;
      final_code  <= `ODIR_FINAL_DIV_RST;
      final_ratio <= 6'h01;
      dis_cfg     <= `ODIR_DIS_CFG_RST;
      oe          <= `ODIR_OE_RST;
    end else if (soft_rst) begin
      vco_low     <= 8'(`ODIR_VCO_DIV_RST & 10'h0FF);
      vco_hi      <= 2'(`ODIR_VCO_DIV_RST >> 8);
      final_code  <= `ODIR_FINAL_DIV_RST;
      final_ratio <= odir_ratio(`ODIR_FINAL_DIV_RST);
      dis_cfg     <= `ODIR_DIS_CFG_RST;
      oe          <= `ODIR_OE_RST;
    end else if (wr_en) begin
      case (req_addr)
        `ODIR_ADDR_VCO_LOW: vco_low <= req_wdata;
        `ODIR_ADDR_DIV_CTRL: begin
          vco_hi      <= req_wdata[`ODIR_VCO_HI_RANGE];
          final_code  <= req_wdata[`ODIR_FINAL_RANGE];
          final_ratio <= odir_ratio(req_wdata[`ODIR_FINAL_RANGE]);
        end
        `ODIR_ADDR_DIS_CFG: dis_cfg <= req_wdata[`ODIR_DIS_RANGE];
        `ODIR_ADDR_OUT_CAL: oe <= req_wdata[`ODIR_OE_BIT];
        default: ;
      endcase
    end
  end

  // Calibration timer, a new start wins over completion
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cal_busy <= `ODIR_CAL_RST;
      cal_cnt  <= 24'h000000;
    end else if (soft_rst) begin
      cal_busy <= `ODIR_CAL_RST;
      cal_cnt  <= 24'h000000;
    end else if (wr_en && (req_addr == `ODIR_ADDR_OUT_CAL) && req_wdata[`ODIR_CAL_BIT]) begin
      cal_busy <= 1'b1;
      cal_cnt  <= 24'h000000;
    end else if (cal_busy) begin
      if (cal_cnt == 24'(CAL_CYCLES - 1)) begin
        cal_busy <= 1'b0;
      end else begin
        cal_cnt <= cal_cnt + 24'h000001;
      end
    end
  end

  // Read data, reserved bits and unlisted addresses read zero
  function automatic odir_byte_t odir_read(input odir_byte_t addr);
    case (addr)
      `ODIR_ADDR_VCO_LOW:  return vco_low;
      `ODIR_ADDR_DIV_CTRL: return {1'b0, final_code, 2'b00, vco_hi};
      `ODIR_ADDR_DIS_CFG:  return {2'b00, dis_cfg, 4'h0};
      `ODIR_ADDR_OUT_CAL:  return {5'h00, oe, 1'b0, cal_busy};
      default:             return 8'h00;
    endcase
  endfunction

  // Read capture and answer pulse
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sys_rd_data <= 8'h00;
      sys_done    <= 1'b0;
    end else begin
      sys_done <= sys_req;
      if (rd_en) begin
        sys_rd_data <= odir_read(req_addr);
      end
    end
  end

  // Outputs toward the synthesizer and driver
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      VCO_OUTPUT_DIVIDER <= `ODIR_VCO_DIV_RST;
      TOTAL_DIVIDE       <= 16'h0000;
      DRIVER_EN          <= 1'b0;
      CLK_OE_N           <= 1'b1;
      CLK_LEVEL          <= 1'b0;
    end else begin
      VCO_OUTPUT_DIVIDER <= vco_div;
      TOTAL_DIVIDE       <= odir_total(vco_div, final_ratio);
      DRIVER_EN          <= oe;
      CLK_OE_N           <= !(oe || dis_cfg == `ODIR_DIS_LOW || dis_cfg == `ODIR_DIS_HIGH);
      CLK_LEVEL          <= !oe && (dis_cfg == `ODIR_DIS_HIGH);
    end
  end
  assign FINAL_DIVIDE_RATIO = final_ratio;
  assign CAL_BUSY           = cal_busy;

  // Register side checks
  property p_soft_reset;
    @(posedge SYS_CLK) disable iff (!RESETN)
      soft_rst |=> (oe == `ODIR_OE_RST) && !cal_busy && (dis_cfg == `ODIR_DIS_CFG_RST) && (vco_div == `ODIR_VCO_DIV_RST);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset left a register off default");

  property p_final_decode;
    @(posedge SYS_CLK) disable iff (!RESETN)
      wr_en && (req_addr == `ODIR_ADDR_DIV_CTRL) && !soft_rst
      |=> (FINAL_DIVIDE_RATIO == 6'h00) == ($past(req_wdata[6:4]) > 3'h5);
  endproperty
  a_final_decode: assert property (p_final_decode) else $error("final ratio zero mismatch");

  property p_final_now;
    @(posedge SYS_CLK) disable iff (!RESETN)
      wr_en && (req_addr == `ODIR_ADDR_DIV_CTRL) |=> FINAL_DIVIDE_RATIO == odir_ratio($past(req_wdata[6:4]));
  endproperty
  a_final_now: assert property (p_final_now) else $error("final ratio not applied at once");

  property p_total;
    @(posedge SYS_CLK) disable iff (!RESETN)
      wr_en ##1 !wr_en |=> TOTAL_DIVIDE == odir_total(VCO_OUTPUT_DIVIDER, FINAL_DIVIDE_RATIO);
  endproperty
  a_total: assert property (p_total) else $error("total divide not product of stages");

  property p_cal_start;
    @(posedge SYS_CLK) disable iff (!RESETN)
      wr_en && (req_addr == `ODIR_ADDR_OUT_CAL) && req_wdata[0] |=> cal_busy && (cal_cnt == 24'h000000);
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration did not start");

  property p_cal_bound;
    @(posedge SYS_CLK) disable iff (!RESETN)
      cal_busy |-> cal_cnt < 24'(CAL_CYCLES);
  endproperty
  a_cal_bound: assert property (p_cal_bound) else $error("calibration overran its limit");

  property p_dis_state;
    @(posedge SYS_CLK) disable iff (!RESETN)
      !oe |=> (CLK_OE_N == ($past(dis_cfg) == 2'h0 || $past(dis_cfg) == 2'h3)) && (CLK_LEVEL == ($past(dis_cfg) == 2'h1));
  endproperty
  a_dis_state: assert property (p_dis_state) else $error("disabled output state wrong");

  property p_driver_on;
    @(posedge SYS_CLK) disable iff (!RESETN)
      oe |=> DRIVER_EN && !CLK_OE_N;
  endproperty
  a_driver_on: assert property (p_driver_on) else $error("enabled driver not driving");

  property p_unmapped;
    @(posedge SYS_CLK) disable iff (!RESETN)
      rd_en && (req_addr == 8'h00 || req_addr == `ODIR_ADDR_SOFT_RST) |=> sys_rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unlisted or reset address read nonzero");

  // Link side checks
  property p_ptr_inc;
    @(posedge LINK_CLK) disable iff (!link_rst_n)
      (state == ODIR_WDATA) && byte_full && scl_fall && !timeout_hit |=> ptr == $past(ptr) + 8'h01;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced after write byte");

  property p_addr_nack;
    @(posedge LINK_CLK) disable iff (!link_rst_n)
      (state == ODIR_ADDR) && byte_full && scl_fall && !timeout_hit && (shreg[7:1] != SLAVE_ADDR)
      |=> (state == ODIR_IDLE) && sda_oe_n;
  endproperty
  a_addr_nack: assert property (p_addr_nack) else $error("foreign address acknowledged");

  property p_timeout;
    @(posedge LINK_CLK) disable iff (!link_rst_n)
      timeout_hit |=> (state == ODIR_IDLE) && sda_oe_n;
  endproperty
  a_timeout: assert property (p_timeout) else $error("stalled transfer not abandoned");

  property p_read_msb;
    @(posedge LINK_CLK) disable iff (!link_rst_n)
      (state == ODIR_ADDR_ACK) && rw && scl_fall && !timeout_hit |=> (state == ODIR_RDATA) && (sda_oe_n == $past(rd_buf[7]));
  endproperty
  a_read_msb: assert property (p_read_msb) else $error("read byte not started with its top bit");

  // Main scenarios
  c_cal_done: cover property (@(posedge SYS_CLK) disable iff (!RESETN) $fell(cal_busy));
  c_soft_rst: cover property (@(posedge SYS_CLK) disable iff (!RESETN) soft_rst);
  c_write: cover property (@(posedge LINK_CLK) disable iff (!link_rst_n) state == ODIR_WDATA_ACK);
  c_read: cover property (@(posedge LINK_CLK) disable iff (!link_rst_n) state == ODIR_RDATA_ACK);

endmodule // odir_regs

// *** test/odir_i2c_mst.sv ***
// Serial bus master model that configures the divider register bank
`timescale 1ns/1ps

module odir_i2c_mst (
  // Clock
  input  wire logic       clk,
  // Bus lines
  input  wire logic       sda,
  output logic            scl,
  output logic            sda_low,
  // Byte seen on the bus with its ninth bit
  output logic            stb,
  output logic [8:0]      rx
);
  localparam int Q = 40; // Quarter bit; SCL high 0.64 us keeps the run short

  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    stb = 1'b0;
    rx = 9'h000;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Start, or repeated start from a low clock
  task automatic start();
    sda_low <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_low <= 1'b1;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask

  task automatic stop();
    sda_low <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_low <= 1'b0;
    tick(Q);
  endtask

  // Nine bits out, line sampled in mid high phase
  task automatic xb(input logic [8:0] d);
    for (int i = 8; i >= 0; i--) begin
      sda_low <= ~d[i];
      tick(Q);
      scl <= 1'b1;
      tick(Q);
      rx[i] <= sda;
      tick(Q);
      scl <= 1'b0;
      tick(Q);
    end
    sda_low <= 1'b0;
    stb <= 1'b1;
    tick(1);
    stb <= 1'b0;
  endtask
endmodule // odir_i2c_mst

// *** test/testbench.sv ***
// Self-checking bench of the divider register bank over its serial bus
`timescale 1ns/1ps

module testbench;
  import odir_pkg::*;
  localparam logic [6:0] SA = 7'h2A;
  logic          sys_clk = 1'b0;
  logic          link_clk = 1'b0;
  logic          rst_n;
  logic          scl, sda_low, sda_o, sda_oe_n, stb;
  logic          drv_en, clk_oe_n, clk_level, cal_busy;
  logic [8:0]    rx;
  odir_vco_div_t vco;
  odir_ratio_t   ratio;
  logic [15:0]   total;
  logic [8:0]    exp_q[$];
  logic [31:0]   lf = 32'h0B56;
  logic [7:0]    lo;
  int            fails = 0;
  int            tests_run = 0;
  int            n;
  wire           sda = ~sda_low & (sda_oe_n | sda_o);

  // Clocks
  always #4 sys_clk = ~sys_clk;
  always #15 link_clk = ~link_clk;

  odir_regs #(.CAL_CYCLES(1000), .SDA_TIMEOUT_CYCLES(800)) u_dut (
    .SYS_CLK(sys_clk), .RESETN(rst_n), .LINK_CLK(link_clk), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .VCO_OUTPUT_DIVIDER(vco), .FINAL_DIVIDE_RATIO(ratio),
    .TOTAL_DIVIDE(total), .DRIVER_EN(drv_en), .CLK_OE_N(clk_oe_n), .CLK_LEVEL(clk_level),
    .CAL_BUSY(cal_busy));
  odir_i2c_mst u_mst (.clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low), .stb(stb), .rx(rx));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Byte with its expected echo and ninth bit
  task automatic bx(input logic [7:0] d, input logic m, input logic [8:0] e);
    exp_q.push_back(e);
    u_mst.xb({d, m});
  endtask

  task automatic hdr(input logic [7:0] r);
    u_mst.start();
    bx({SA, 1'b0}, 1'b1, {SA, 2'b00});
    bx(r, 1'b1, {r, 1'b0});
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] d[$]);
    hdr(r);
    foreach (d[i])
      bx(d[i], 1'b1, {d[i], 1'b0});
    u_mst.stop();
  endtask

  task automatic rd(input logic [7:0] r, input logic [7:0] e[$]);
    hdr(r);
    u_mst.start();
    bx({SA, 1'b1}, 1'b1, {SA, 2'b10});
    foreach (e[i])
      bx(8'hFF, i == e.size() - 1, {e[i], i == e.size() - 1});
    u_mst.stop();
  endtask

  // Outputs against divider value, ratio and {driver, float, level, busy}
  task automatic outs(input logic [9:0] v, input logic [5:0] f, input logic [3:0] m);
    chk(vco, v);
    chk(ratio, f);
    chk(total, {6'h00, v} * {10'h000, f});
    chk({drv_en, clk_oe_n, clk_level, cal_busy}, m);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Oldest note against each byte seen on the bus
  always @(posedge sys_clk) begin
    if (stb === 1'b1)
      chk({7'h00, rx}, {7'h00, exp_q.pop_front()});
  end

  // Watchdog
  initial begin
    repeat (99000) @(posedge sys_clk);
    fails++;
    complete_run();
  end

  initial begin
    rst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge sys_clk);
    outs(10'h00A, 6'h01, 4'h8);
    wr(8'h84, '{8'h00});
    for (int s = 0; s < 4; s++) begin
      wr(8'h0E, '{8'(s << 4)});
      chk({clk_oe_n, clk_level}, {s == 0 || s == 3, s == 1});
    end
    lf = lfsr(lf);
    lo = {lf[7:1], 1'b0};
    wr(8'h0A, '{lo, 8'hD2});
    outs({2'h2, lo}, 6'h20, 4'h4);
    wr(8'h84, '{8'h01});
    chk(cal_busy, 1'b1);
    n = 0;
    while (cal_busy === 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n inside {[600:1000]}, 1'b1);
    rd(8'h0A, '{lo, 8'h52, 8'h00});
    wr(8'h84, '{8'h04});
    chk(drv_en, 1'b1);
    for (int c = 0; c < 8; c++) begin
      wr(8'h0B, '{8'(c << 4)});
      chk(ratio, c < 6 ? 6'h01 << c : 6'h00);
    end
    u_mst.start();
    bx({SA ^ 7'h01, 1'b0}, 1'b1, {SA ^ 7'h01, 2'b01});
    u_mst.stop();
    // Data line held low past the limit, so the next byte goes unanswered
    u_mst.start();
    u_mst.tick(3300);
    bx({SA, 1'b0}, 1'b1, {SA, 2'b01});
    u_mst.stop();
    wr(8'h80, '{8'h80});
    outs(10'h00A, 6'h01, 4'h8);
    complete_run();
  end
endmodule // testbench
